// >>> core/timer_map.svh
// register offsets, field positions, reset values and timing counts of the dual timer
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
`define TMR_ADDR_W 4
`define TMR_OFS_CTRL0 4'h0
`define TMR_OFS_PRE0 4'h1
`define TMR_OFS_CMP0 4'h2
`define TMR_OFS_CNT0 4'h3
`define TMR_OFS_CTRL1 4'h4
`define TMR_OFS_PRE1 4'h5
`define TMR_OFS_CMP1 4'h6
`define TMR_OFS_CNT1 4'h7
`define TMR_OFS_STAT 4'h8
`define TMR_OFS_CLR 4'h9
`define TMR_OFS_IEN 4'hA
`define TMR_OFS_PIN 4'hB
`define TMR_CTRL_EN_BIT 0
`define TMR_CTRL_DIV16_BIT 1
`define TMR_CTRL_OCE_BIT 2
`define TMR_CTRL_TOG_BIT 3
`define TMR_CTRL_RST 4'h0
`define TMR_PRE_RST 8'h00
`define TMR_CMP_RST 16'hFFFF
`define TMR_DIV16_LAST 4'hF
`define TMR_BUS_DIV_LAST 1'h1
`define TMR_PIN_IDLE 1'h1
`endif

// >>> core/timer_pkg.sv
// types shared by the dual timer modules
package timer_pkg;
  typedef struct packed {
    logic toggle;
    logic out_en;
    logic div16;
    logic enable;
  } tmr_ctrl_t;

  typedef struct packed {
    tmr_ctrl_t ctrl;
    logic [7:0] prescale;
    logic [15:0] compare;
  } tmr_cfg_t;

  typedef struct packed {
    logic [15:0] count;
    logic match;
  } tmr_stat_t;
endpackage

// >>> core/tick_divider.sv
// bus clock enable and per-timer clock select with 8-bit prescaler
`timescale 1ns/1ps
`include "timer_map.svh"
module tick_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_tick,
  input wire logic enable,
  input wire logic div16,
  input wire logic [7:0] prescale,
  output logic tick
);
  typedef struct packed {
    logic [3:0] div;
    logic [7:0] pre;
    logic tick;
  } state_t;
  state_t s_reg;
  state_t s_next;
  logic src;

  always_comb
  begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    src = 1'b0;
    if (!enable)
    begin
      s_next.div = 4'h0;
      s_next.pre = 8'h00;
    end
    else if (bus_tick)
    begin
      s_next.div = s_reg.div + 4'h1;
      src = !div16 || (s_reg.div == `TMR_DIV16_LAST); // R05
      if (src)
      begin
        // prescale value n divides by n+1 so zero means straight through
        if (s_reg.pre >= prescale) // R04
        begin
          s_next.pre = 8'h00;
          s_next.tick = 1'b1;
        end
        else
        begin
          s_next.pre = s_reg.pre + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
endmodule

// >>> core/compare_unit.sv
// free-running 16-bit counter with compare match detection
`timescale 1ns/1ps
module compare_unit (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [15:0] compare,
  input wire logic cnt_clear,
  output timer_pkg::tmr_stat_t stat
);
  typedef struct packed {
    logic [15:0] count;
    logic match;
  } state_t;
  state_t s_reg;
  state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.match = 1'b0;
    if (cnt_clear)
    begin
      s_next.count = 16'h0000;
    end
    else if (tick)
    begin
      // wraps from FFFF to 0000 without stopping
      s_next.count = s_reg.count + 16'h0001; // R01 R07
      s_next.match = (s_next.count == compare); // R02
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign stat = {s_reg.count, s_reg.match};
endmodule

// >>> core/dual_timer.sv
// two free-running compare timers with register port, interrupt and output pin
//
// Summary of operation
// R01: two independent timers each hold a 16-bit counter advancing on every prescaled tick.
// R02: a counter equal to its compare value raises an interrupt and/or the output pin event.
// R03: only the first timer drives the compare output pin; the second only interrupts.
// R04: each timer divides its selected clock by a programmable 8-bit prescale value plus one.
// R05: the timer clock is the bus clock (half the system clock) divided by 1 or by 16.
// R06: on a match the pin either emits a one-tick active-low pulse or toggles its level.
// R07: each counter wraps from its maximum to zero and keeps counting by itself.
`timescale 1ns/1ps
`include "timer_map.svh"
module dual_timer (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic IRQ,
  output logic COMPARE_OUTPUT_PIN
);
  typedef struct packed {
    timer_pkg::tmr_cfg_t [1:0] cfg;
    logic [1:0] status;
    logic [1:0] irq_en;
    logic bus_tick;
    logic pin;
    logic pulse_on;
    logic irq;
    logic [15:0] rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [1:0] tick;
  logic [1:0] cnt_clear;
  timer_pkg::tmr_stat_t [1:0] stat;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : timer
      tick_divider div_i (
        .clk(SYS_CLK),
        .rst(RST),
        .bus_tick(s_reg.bus_tick),
        .enable(s_reg.cfg[g].ctrl.enable),
        .div16(s_reg.cfg[g].ctrl.div16),
        .prescale(s_reg.cfg[g].prescale),
        .tick(tick[g])
      );
      compare_unit cmp_i (
        .clk(SYS_CLK),
        .rst(RST),
        .tick(tick[g]),
        .compare(s_reg.cfg[g].compare),
        .cnt_clear(cnt_clear[g]),
        .stat(stat[g])
      );
    end
  endgenerate

  // a write to a count register restarts that counter from zero
  assign cnt_clear = {WR && (ADDR == `TMR_OFS_CNT1), WR && (ADDR == `TMR_OFS_CNT0)};

  always_comb
  begin
    s_next = s_reg;
    s_next.rdata = 16'h0000;
    // bus clock runs at half the system clock
    s_next.bus_tick = !s_reg.bus_tick; // R05
    if (WR)
    begin
      case (ADDR)
        `TMR_OFS_CTRL0: s_next.cfg[0].ctrl = WDATA[3:0];
        `TMR_OFS_PRE0: s_next.cfg[0].prescale = WDATA[7:0];
        `TMR_OFS_CMP0: s_next.cfg[0].compare = WDATA;
        `TMR_OFS_CTRL1: s_next.cfg[1].ctrl = {2'b00, WDATA[1:0]}; // R03
        `TMR_OFS_PRE1: s_next.cfg[1].prescale = WDATA[7:0];
        `TMR_OFS_CMP1: s_next.cfg[1].compare = WDATA;
        `TMR_OFS_IEN: s_next.irq_en = WDATA[1:0];
        default: s_next.irq_en = s_reg.irq_en;
      endcase
    end
    if (WR && ADDR == `TMR_OFS_CLR)
    begin
      s_next.status = s_reg.status & ~WDATA[1:0];
    end
    // set wins over a clear in the same cycle
    s_next.status = s_next.status | {stat[1].match, stat[0].match}; // R02
    if (RD)
    begin
      case (ADDR)
        `TMR_OFS_CTRL0: s_next.rdata = {12'h000, s_reg.cfg[0].ctrl};
        `TMR_OFS_PRE0: s_next.rdata = {8'h00, s_reg.cfg[0].prescale};
        `TMR_OFS_CMP0: s_next.rdata = s_reg.cfg[0].compare;
        `TMR_OFS_CNT0: s_next.rdata = stat[0].count;
        `TMR_OFS_CTRL1: s_next.rdata = {12'h000, s_reg.cfg[1].ctrl};
        `TMR_OFS_PRE1: s_next.rdata = {8'h00, s_reg.cfg[1].prescale};
        `TMR_OFS_CMP1: s_next.rdata = s_reg.cfg[1].compare;
        `TMR_OFS_CNT1: s_next.rdata = stat[1].count;
        `TMR_OFS_STAT: s_next.rdata = {14'h0000, s_reg.status};
        `TMR_OFS_IEN: s_next.rdata = {14'h0000, s_reg.irq_en};
        `TMR_OFS_PIN: s_next.rdata = {15'h0000, s_reg.pin};
        default: s_next.rdata = 16'h0000;
      endcase
    end
    // pulse lasts one timer tick so it scales with the chosen rate
    if (s_reg.pulse_on && tick[0])
    begin
      s_next.pulse_on = 1'b0;
      s_next.pin = `TMR_PIN_IDLE;
    end
    if (!s_reg.cfg[0].ctrl.out_en)
    begin
      s_next.pin = `TMR_PIN_IDLE;
      s_next.pulse_on = 1'b0;
    end
    else if (stat[0].match) // R03
    begin
      if (s_reg.cfg[0].ctrl.toggle)
      begin
        s_next.pin = !s_reg.pin; // R06
        s_next.pulse_on = 1'b0;
      end
      else
      begin
        s_next.pin = 1'b0; // R06
        s_next.pulse_on = 1'b1;
      end
    end
    s_next.irq = |(s_next.status & s_next.irq_en);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < 2; i++)
      begin
        s_reg.cfg[i].ctrl <= `TMR_CTRL_RST;
        s_reg.cfg[i].prescale <= `TMR_PRE_RST;
        s_reg.cfg[i].compare <= `TMR_CMP_RST;
      end
      s_reg.status <= 2'h0;
      s_reg.irq_en <= 2'h0;
      s_reg.bus_tick <= 1'b0;
      s_reg.pin <= `TMR_PIN_IDLE;
      s_reg.pulse_on <= 1'b0;
      s_reg.irq <= 1'b0;
      s_reg.rdata <= 16'h0000;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign RDATA = s_reg.rdata;
  assign IRQ = s_reg.irq;
  assign COMPARE_OUTPUT_PIN = s_reg.pin;
endmodule

// >>> verification/dual_timer_sva.sv
// port-level checker for the dual timer
`timescale 1ns/1ps
module dual_timer_chk (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic IRQ,
  input wire logic COMPARE_OUTPUT_PIN
);
  logic [1:0] ien_reg;
  logic oe_reg;
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ien_reg <= 2'h0;
      oe_reg <= 1'b0;
    end
    else if (WR && ADDR == 4'hA)
      ien_reg <= WDATA[1:0];
    else if (WR && ADDR == 4'h0)
      oe_reg <= WDATA[2];
  end
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  reset_values_a: assert property ($past(RST) |-> COMPARE_OUTPUT_PIN && !IRQ
    && RDATA == 16'h0000) else $error("outputs not at reset values");
  rdata_quiet_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside read answer");
  irq_enable_a: assert property (IRQ |-> ien_reg != 2'h0 || $past(ien_reg) != 2'h0)
    else $error("interrupt with all sources masked");
  irq_status_a: assert property (RD && ADDR == 4'h8 && IRQ |=> RDATA != 16'h0000)
    else $error("interrupt without status bit");
  ctrl1_narrow_a: assert property (RD && ADDR == 4'h4 |=> RDATA[15:2] == 14'h0000)
    else $error("second timer shows output control bits");
  pin_quiet_a: assert property (!oe_reg && !$past(oe_reg) |-> COMPARE_OUTPUT_PIN)
    else $error("pin moved with output disabled");
  pre_width_a: assert property (RD && ADDR == 4'h1 |=> RDATA[15:8] == 8'h00)
    else $error("prescaler wider than eight bits");
endmodule
bind dual_timer dual_timer_chk chk_i (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .COMPARE_OUTPUT_PIN(COMPARE_OUTPUT_PIN));

// >>> verification/tb_dual_timer.sv
// register-level testbench for the dual timer
`timescale 1ns/1ps
module tb_dual_timer;
  logic SYS_CLK, RST, WR, RD, IRQ, COMPARE_OUTPUT_PIN;
  logic [3:0] ADDR;
  logic [15:0] WDATA, RDATA, v;
  int miscompares = 0;
  int checks_done = 0;
  int n;
  dual_timer dut (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IRQ(IRQ), .COMPARE_OUTPUT_PIN(COMPARE_OUTPUT_PIN));
  initial
  begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    miscompares++;
    results;
  end
  initial
  begin
    RST <= 1'b1;
    WR <= 1'b0;
    RD <= 1'b0;
    ADDR <= 4'h0;
    WDATA <= 16'h0000;
    repeat (8) @(posedge SYS_CLK);
    RST <= 1'b0;
    for (int i = 0; i < 13; i++)
    begin
      rd(4'(i), v);
      chk(v, (i == 2 || i == 6) ? 16'hFFFF : {15'h0000, i == 11});
    end
    // prescale 3 on the bus tick first, then div16 without prescale: both give ten counts
    for (int i = 0; i < 2; i++)
    begin
      wr(4'h1, i ? 16'h0000 : 16'h0003);
      wr(4'h0, i ? 16'h0003 : 16'h0001);
      wr(4'h3, 16'h0000);
      repeat (i ? 318 : 78) @(posedge SYS_CLK);
      rd(4'h3, v);
      chk(16'(v inside {[9:11]}), 16'h0001);
    end
    wr(4'h1, 16'h0000);
    wr(4'h2, 16'h0014);
    wr(4'hA, 16'h0001);
    wr(4'h0, 16'h000D);
    wr(4'h3, 16'h0000);
    repeat (60) @(posedge SYS_CLK);
    #1 chk({14'h0000, IRQ, COMPARE_OUTPUT_PIN}, 16'h0002);
    rd(4'h8, v);
    chk(v, 16'h0001);
    wr(4'h9, 16'h0001);
    wr(4'h6, 16'h0014);
    wr(4'h4, 16'h000D);
    wr(4'h7, 16'h0000);
    repeat (60) @(posedge SYS_CLK);
    rd(4'h8, v);
    chk(v, 16'h0002);
    chk({14'h0000, IRQ, COMPARE_OUTPUT_PIN}, 16'h0000);
    rd(4'h4, v);
    chk(v, 16'h0001);
    wr(4'hA, 16'h0003);
    repeat (3) @(posedge SYS_CLK);
    #1 chk({15'h0000, IRQ}, 16'h0001);
    wr(4'h9, 16'h0002);
    repeat (3) @(posedge SYS_CLK);
    #1 chk({15'h0000, IRQ}, 16'h0000);
    wr(4'h0, 16'h0001);
    wr(4'h1, 16'h0003);
    wr(4'h0, 16'h0005);
    wr(4'h3, 16'h0000);
    n = 0;
    while (COMPARE_OUTPUT_PIN && n < 400)
    begin
      @(negedge SYS_CLK);
      n++;
    end
    n = 0;
    while (!COMPARE_OUTPUT_PIN && n < 100)
    begin
      @(negedge SYS_CLK);
      n++;
    end
    chk(16'(n inside {[7:9]}), 16'h0001);
    // only eight prescale bits are kept, the upper byte reads back as zero
    wr(4'h1, 16'hFF5A);
    rd(4'h1, v);
    chk(v, 16'h005A);
    wr(4'h5, 16'hA5C3);
    rd(4'h5, v);
    chk(v, 16'h00C3);
    results;
  end
endmodule
